/* File: hdl/lcs_link_regs.sv */
// lcs_link_regs: apb register bank for processor, external and static link setup
`timescale 1ns/10ps
`default_nettype none
module lcs_link_regs #(
  parameter int NUM_PL = 8  // processor links served
) (
  input  wire logic                                          pclk,
  input  wire logic                                          presetn,
  input  wire logic                                          psel,
  input  wire logic                                          penable,
  input  wire logic                                          pwrite,
  input  wire logic [lcs_pkg::ADDR_W-1:0]                    paddr,
  input  wire logic [31:0]                                   pwdata,
  output var  logic [31:0]                                   prdata,
  output var  logic                                          pready,
  output var  logic                                          pslverr,
  input  wire lcs_pkg::lcs_pl_stat_s [NUM_PL-1:0]            pl_stat,
  input  wire lcs_pkg::lcs_xl_ev_s [lcs_pkg::NUM_XL-1:0]     xl_ev,
  output var  logic [NUM_PL-1:0][1:0]                        pl_network,
  output var  lcs_pkg::lcs_xl_cfg_s [lcs_pkg::NUM_XL-1:0]    xl_cfg,
  output var  logic [lcs_pkg::NUM_XL-1:0]                    xl_greet,
  output var  logic [lcs_pkg::NUM_XL-1:0]                    xl_rx_reset,
  output var  logic [lcs_pkg::NUM_XL-1:0]                    xl_cred_held,
  output var  lcs_pkg::lcs_st_cfg_s [lcs_pkg::NUM_XL-1:0]    st_cfg
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the group holds at most eight entries; more would alias the next group
  if (NUM_PL < 1 || NUM_PL > (1 << lcs_pkg::GROUP_W)) begin : g_bad_pl
    $error("NUM_PL must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [lcs_pkg::IDX_W-1:0]   idx;      // register index
  logic [lcs_pkg::GROUP_W-1:0] sub;      // entry inside a group
  logic                        aligned;  // low address bits clear
  logic                        hit_pl;   // processor link entry
  logic                        hit_xl;   // external link entry
  logic                        hit_st;   // static forwarding entry
  logic                        miss;     // no register answers

  assign idx     = paddr[lcs_pkg::ADDR_W-1:lcs_pkg::BYTE_SH];
  assign sub     = idx[lcs_pkg::GROUP_W-1:0];
  assign aligned = (paddr[lcs_pkg::BYTE_SH-1:0] == '0);

  // group compare on upper index bits, entry range on the low ones
  always_comb begin
    hit_pl = aligned && (idx[lcs_pkg::IDX_W-1:lcs_pkg::GROUP_W] ==
             lcs_pkg::PL_IDX[lcs_pkg::IDX_W-1:lcs_pkg::GROUP_W]) &&
             (32'(sub) < NUM_PL);
    hit_xl = aligned && (idx[lcs_pkg::IDX_W-1:lcs_pkg::GROUP_W] ==
             lcs_pkg::XL_IDX[lcs_pkg::IDX_W-1:lcs_pkg::GROUP_W]);
    hit_st = aligned && (idx[lcs_pkg::IDX_W-1:lcs_pkg::GROUP_W] ==
             lcs_pkg::ST_IDX[lcs_pkg::IDX_W-1:lcs_pkg::GROUP_W]);
    miss   = !(hit_pl || hit_xl || hit_st);
  end

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------
  lcs_pkg::lcs_apb_e state;   // setup seen or not
  logic              wr_fire; // write takes effect this edge
  logic [31:0]       rd_word; // read data for current address

  // answer one cycle after setup: pready and data are registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= lcs_pkg::APB_IDLE;
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      unique case (state)
        lcs_pkg::APB_IDLE: begin
          // setup phase: latch the answer now
          if (psel && !penable) begin
            state   <= lcs_pkg::APB_ACC;
            pready  <= 1'b1;
            prdata  <= pwrite ? '0 : rd_word;
            pslverr <= miss;
          end
        end
        lcs_pkg::APB_ACC: begin
          // access completes at this edge; drop back for the next setup
          state   <= lcs_pkg::APB_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

  // unmapped writes are refused and change nothing
  assign wr_fire = (state == lcs_pkg::APB_ACC) && psel && penable && pwrite && !pslverr;

  // ----------------------------------------------------------------
  // write decode, per entry strobes
  // ----------------------------------------------------------------
  lcs_pkg::lcs_pl_word_s       wd_pl;   // write data as proc link word
  lcs_pkg::lcs_xl_word_s       wd_xl;   // write data as ext link word
  lcs_pkg::lcs_st_word_s       wd_st;   // write data as static word
  lcs_pkg::lcs_xl_cfg_s        wd_cfg;  // ext link config part of a write
  logic [NUM_PL-1:0]           wr_pl;   // one-hot proc link write
  logic [lcs_pkg::NUM_XL-1:0]  wr_xl;   // one-hot ext link write
  logic [lcs_pkg::NUM_XL-1:0]  wr_st;   // one-hot static register write

  assign wd_pl = lcs_pkg::lcs_pl_word_s'(pwdata);
  assign wd_xl = lcs_pkg::lcs_xl_word_s'(pwdata);
  assign wd_st = lcs_pkg::lcs_st_word_s'(pwdata);

  // only writable fields are picked out, reserved bits are dropped
  always_comb begin
    wd_cfg.en      = wd_xl.en;
    wd_cfg.wide    = wd_xl.wide;
    wd_cfg.sym_gap = wd_xl.sym_gap;
    wd_cfg.tok_gap = wd_xl.tok_gap;
    for (int i = 0; i < NUM_PL; i++) begin
      wr_pl[i] = wr_fire && hit_pl && (sub == lcs_pkg::GROUP_W'(i));
    end
    for (int i = 0; i < lcs_pkg::NUM_XL; i++) begin
      wr_xl[i] = wr_fire && hit_xl && (sub == lcs_pkg::GROUP_W'(i));
      wr_st[i] = wr_fire && hit_st && (sub == lcs_pkg::GROUP_W'(i));
    end
  end

  // ----------------------------------------------------------------
  // processor link network fields
  // ----------------------------------------------------------------
  // network membership, the only writable proc link field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pl_network <= '0;
    end else begin
      for (int i = 0; i < NUM_PL; i++) begin
        if (wr_pl[i]) begin
          pl_network[i] <= wd_pl.net;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // external link configuration
  // ----------------------------------------------------------------
  // enable, width and gap fields; enable also steers the pin mux outside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xl_cfg <= '0;
    end else begin
      for (int i = 0; i < lcs_pkg::NUM_XL; i++) begin
        if (wr_xl[i]) begin
          xl_cfg[i] <= wd_cfg;
        end
      end
    end
  end

  // one-cycle command pulses toward the link layer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xl_greet    <= '0;
      xl_rx_reset <= '0;
    end else begin
      for (int i = 0; i < lcs_pkg::NUM_XL; i++) begin
        xl_greet[i]    <= wr_xl[i] && wd_xl.greet;
        xl_rx_reset[i] <= wr_xl[i] && wd_xl.rx_rst;
      end
    end
  end

  // ----------------------------------------------------------------
  // external link status
  // ----------------------------------------------------------------
  logic [lcs_pkg::NUM_XL-1:0] rx_err;   // sticky receive error
  logic [lcs_pkg::NUM_XL-1:0] cred_iss; // credit given to remote

  // credit held: granted by remote, cleared by a greeting write;
  // a grant in the clearing cycle wins so a credit is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xl_cred_held <= '0;
    end else begin
      for (int i = 0; i < lcs_pkg::NUM_XL; i++) begin
        if (xl_ev[i].credit_grant) begin
          xl_cred_held[i] <= 1'b1;
        end else if (wr_xl[i] && wd_xl.greet) begin
          xl_cred_held[i] <= 1'b0;
        end
      end
    end
  end

  // error is sticky until the receiver is reset; new errors win
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_err <= '0;
    end else begin
      for (int i = 0; i < lcs_pkg::NUM_XL; i++) begin
        if (xl_ev[i].rx_overflow || xl_ev[i].bad_token) begin
          rx_err[i] <= 1'b1;
        end else if (wr_xl[i] && wd_xl.rx_rst) begin
          rx_err[i] <= 1'b0;
        end
      end
    end
  end

  // issued credit mirrors the link layer level, registered once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cred_iss <= '0;
    end else begin
      for (int i = 0; i < lcs_pkg::NUM_XL; i++) begin
        cred_iss[i] <= xl_ev[i].cred_iss;
      end
    end
  end

  // ----------------------------------------------------------------
  // static forwarding
  // ----------------------------------------------------------------
  // stored by link letter so the outputs need no remap logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_cfg <= '0;
    end else begin
      for (int r = 0; r < lcs_pkg::NUM_XL; r++) begin
        if (wr_st[r]) begin
          st_cfg[lcs_pkg::ST_LINK_OF_REG[r]].en        <= wd_st.en;
          st_cfg[lcs_pkg::ST_LINK_OF_REG[r]].dest_core <= wd_st.dest_core;
          st_cfg[lcs_pkg::ST_LINK_OF_REG[r]].chan      <= wd_st.chan;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  lcs_pkg::lcs_pl_word_s pl_rd;     // proc link word view
  lcs_pkg::lcs_xl_word_s xl_rd;     // ext link word view
  lcs_pkg::lcs_st_word_s st_rd;     // static word view
  lcs_pkg::lcs_kind_e    sel_kind;  // addressed link target kind
  logic [1:0]            sel_busy;  // addressed link busy pair
  logic [2:0]            st_link;   // letter behind addressed static reg

  assign st_link = lcs_pkg::ST_LINK_OF_REG[sub];

  // reserved bits stay zero because every view starts cleared
  always_comb begin
    pl_rd    = '0;
    xl_rd    = '0;
    st_rd    = '0;
    sel_kind = lcs_pkg::KIND_SWITCH;
    sel_busy = '0;
    rd_word  = '0;
    if (hit_pl) begin
      sel_kind       = pl_stat[sub].kind;
      sel_busy       = {pl_stat[sub].dst_busy, pl_stat[sub].src_busy};
      pl_rd.kind     = pl_stat[sub].kind;
      pl_rd.target   = pl_stat[sub].target;
      pl_rd.net      = pl_network[sub];
      pl_rd.junk     = pl_stat[sub].junk;
      pl_rd.dst_busy = pl_stat[sub].dst_busy;
      pl_rd.src_busy = pl_stat[sub].src_busy;
      rd_word        = pl_rd;
    end else if (hit_xl) begin
      // greeting and receiver reset are write-only and read zero
      xl_rd.en        = xl_cfg[sub].en;
      xl_rd.wide      = xl_cfg[sub].wide;
      xl_rd.rx_err    = rx_err[sub];
      xl_rd.cred_iss  = cred_iss[sub];
      xl_rd.cred_held = xl_cred_held[sub];
      xl_rd.sym_gap   = xl_cfg[sub].sym_gap;
      xl_rd.tok_gap   = xl_cfg[sub].tok_gap;
      rd_word         = xl_rd;
    end else if (hit_st) begin
      st_rd.en        = st_cfg[st_link].en;
      st_rd.dest_core = st_cfg[st_link].dest_core;
      st_rd.chan      = st_cfg[st_link].chan;
      rd_word         = st_rd;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  lcs_pkg::lcs_pl_word_s prd_pl;  // read data as proc link word
  lcs_pkg::lcs_xl_word_s prd_xl;  // read data as ext link word
  assign prd_pl = lcs_pkg::lcs_pl_word_s'(prdata);
  assign prd_xl = lcs_pkg::lcs_xl_word_s'(prdata);

  sequence rd_setup_s;
    state == lcs_pkg::APB_IDLE && psel && !penable && !pwrite;
  endsequence
  sequence pl_read_s;
    rd_setup_s ##0 hit_pl;
  endsequence
  // ext link read: same setup, ext group hit
  sequence xl_read_s;
    rd_setup_s ##0 hit_xl;
  endsequence
  // refused write: access cycle with the error answer standing
  sequence bad_write_s;
    state == lcs_pkg::APB_ACC && psel && penable && pwrite && pslverr;
  endsequence
  sequence pulse_once_s(sig);
    sig ##1 !sig;
  endsequence

  pl_kind_a: assert property (pl_read_s |=> prd_pl.kind == $past(sel_kind))
    else $error("proc link kind read wrong");
  pl_busy_a: assert property (pl_read_s
    |=> {prd_pl.dst_busy, prd_pl.src_busy} == $past(sel_busy))
    else $error("proc link busy bits read wrong");
  // destination link number and junk flag pass straight through
  pl_target_a: assert property (pl_read_s |=> prd_pl.target == $past(pl_stat[sub].target))
    else $error("proc link target read wrong");
  pl_junk_a: assert property (pl_read_s |=> prd_pl.junk == $past(pl_stat[sub].junk))
    else $error("proc link junk bit read wrong");
  pl_rsv_a: assert property (pl_read_s
    |=> prd_pl.r31 == '0 && prd_pl.r15 == '0 && !prd_pl.r3)
    else $error("reserved proc link bits not zero");
  pl_net_a: assert property (wr_fire && hit_pl
    |=> pl_network[$past(sub)] == $past(wd_pl.net))
    else $error("network field not written");
  xl_cfg_a: assert property (wr_fire && hit_xl |=> xl_cfg[$past(sub)] == $past(wd_cfg))
    else $error("ext link config not written");
  st_map_a: assert property (wr_fire && hit_st
    |=> st_cfg[$past(st_link)].chan == $past(wd_st.chan))
    else $error("static register steered wrong link");
  // write-only command bits and reserved bits never show on a read
  xl_rsv_a: assert property (xl_read_s
    |=> prd_xl.r29 == '0 && !prd_xl.greet && !prd_xl.rx_rst && !prd_xl.r22)
    else $error("reserved ext link bits not zero");
  xl_gap_a: assert property (xl_read_s
    |=> {prd_xl.sym_gap, prd_xl.tok_gap} == $past({xl_cfg[sub].sym_gap, xl_cfg[sub].tok_gap}))
    else $error("idle gap fields read wrong");
  st_en_a: assert property (wr_fire && hit_st
    |=> {st_cfg[$past(st_link)].en, st_cfg[$past(st_link)].dest_core} ==
        $past({wd_st.en, wd_st.dest_core}))
    else $error("static enable or core not written");
  // a refused write leaves every setting as it was
  wr_refused_a: assert property (bad_write_s
    |=> $stable(pl_network) && $stable(xl_cfg) && $stable(st_cfg))
    else $error("refused write changed a setting");
  bus_answer_a: assert property (rd_setup_s |=> pready ##1 !pready)
    else $error("apb answer not one access cycle");

  for (genvar g = 0; g < lcs_pkg::NUM_XL; g++) begin : g_xl_chk
    greet_pulse_a: assert property (wr_xl[g] && wd_xl.greet && !xl_ev[g].credit_grant
      |=> pulse_once_s(xl_greet[g]) ##0 !xl_cred_held[g])
      else $error("greeting did not pulse and clear credit");
    rx_reset_a: assert property (wr_xl[g] && wd_xl.rx_rst |=> pulse_once_s(xl_rx_reset[g]))
      else $error("receiver reset did not pulse");
    rx_err_a: assert property (xl_ev[g].rx_overflow || xl_ev[g].bad_token |=> rx_err[g])
      else $error("receive error not flagged");
    cred_set_a: assert property (xl_ev[g].credit_grant |=> xl_cred_held[g])
      else $error("credit grant lost");
    // issued credit follows the link layer one cycle late
    iss_mirror_a: assert property (cred_iss[g] != xl_ev[g].cred_iss
      |=> cred_iss[g] == $past(xl_ev[g].cred_iss))
      else $error("issued credit bit not mirrored");
  end

endmodule
`default_nettype wire

/* File: hdl/lcs_pkg.sv */
// lcs_pkg: register layouts, carriers and constants of the link config/status bank
//
// Contract
// - proc link status shows target kind
// - proc link status shows destination link number
// - proc link network field writable, resets zero
// - junk bit reads one while discarding
// - dest and source busy bits reported
// - ext link enable bit, 1 on, 0 off
// - width bit: 0 two-wire, 1 five-wire
// - error bit on overflow or bad token
// - credit-issued bit, resets zero
// - credit-held bit, resets zero
// - greeting write clears credit, sends greeting
// - receiver reset write restarts token framing
// - inter-symbol idle gap minus one, reset zero
// - inter-token idle gap minus one, reset zero
// - ext link registers form eight-entry array
// - static enable forwards all, no routing
// - static destination core select bit
// - static destination channel endpoint field
// - static registers order C,D,A,B,G,H,E,F
`default_nettype none
package lcs_pkg;
  // ----------------------------------------------------------------
  // address map, register indices (byte address is index times four)
  // ----------------------------------------------------------------
  localparam int          ADDR_W  = 12;      // apb byte address width
  localparam int          BYTE_SH = 2;       // word index starts here
  localparam int          IDX_W   = 10;      // register index width
  localparam int          GROUP_W = 3;       // index bits inside a group
  localparam int          NUM_XL  = 8;       // external links, letters a..h
  localparam logic [9:0]  PL_IDX  = 10'h040; // processor link group
  localparam logic [9:0]  XL_IDX  = 10'h080; // external link group
  localparam logic [9:0]  ST_IDX  = 10'h0A0; // static forwarding group
  localparam int          GAP_W   = 11;      // idle gap field width
  // static register r steers link letter ST_LINK_OF_REG[r] (a=0 .. h=7)
  localparam logic [2:0]  ST_LINK_OF_REG [8] = '{3'h2, 3'h3, 3'h0, 3'h1,
                                                 3'h6, 3'h7, 3'h4, 3'h5};
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {KIND_SWITCH = 2'h0, KIND_PROC = 2'h1,
                            KIND_CTRL = 2'h2, KIND_UNDEF = 2'h3} lcs_kind_e;
  typedef enum logic [1:0] {APB_IDLE = 2'b01, APB_ACC = 2'b10} lcs_apb_e;
  typedef struct packed {
    logic [5:0] r31; lcs_kind_e kind; logic [7:0] target; logic [9:0] r15;
    logic [1:0] net; logic r3; logic junk; logic dst_busy; logic src_busy;
  } lcs_pl_word_s;
  typedef struct packed {
    logic en; logic wide; logic [1:0] r29; logic rx_err; logic cred_iss;
    logic cred_held; logic greet; logic rx_rst; logic r22;
    logic [GAP_W-1:0] sym_gap; logic [GAP_W-1:0] tok_gap;
  } lcs_xl_word_s;
  typedef struct packed {
    logic en; logic [21:0] r30; logic dest_core; logic [2:0] r7; logic [4:0] chan;
  } lcs_st_word_s;
  // live status of one processor link from the switch core
  typedef struct packed {
    lcs_kind_e kind; logic [7:0] target; logic junk; logic dst_busy; logic src_busy;
  } lcs_pl_stat_s;
  // link layer events: pulses except cred_iss, which is a level
  typedef struct packed {
    logic rx_overflow; logic bad_token; logic cred_iss; logic credit_grant;
  } lcs_xl_ev_s;
  typedef struct packed {
    logic en; logic wide; logic [GAP_W-1:0] sym_gap; logic [GAP_W-1:0] tok_gap;
  } lcs_xl_cfg_s;
  typedef struct packed {
    logic en; logic dest_core; logic [4:0] chan;
  } lcs_st_cfg_s;
endpackage
`default_nettype wire

/* File: verification/lcs_link_model.sv */
// lcs_link_model: remote link endpoint that answers greetings with credit
`timescale 1ns/10ps
`default_nettype none
module lcs_link_model (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [7:0]                xl_greet, // greeting pulses
  input  wire logic [7:0]                ovf_req,  // fault orders
  input  wire logic [7:0]                bad_req,
  input  wire logic [7:0]                iss_lvl,  // issued credit level
  output var  lcs_pkg::lcs_xl_ev_s [7:0] xl_ev
);
  // ----------------------------------------------------------------
  // credit return delay
  // ----------------------------------------------------------------
  logic [2:0] wait_cnt [8]; // cycles until credit comes back
  // odd links answer slowly, so a clear can be seen before the grant
  always_ff @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < 8; i++) begin
      if (!presetn) begin
        wait_cnt[i] <= 3'h0;
      end else if (xl_greet[i]) begin
        wait_cnt[i] <= i[0] ? 3'h7 : 3'h1;
      end else if (wait_cnt[i] != 3'h0) begin
        wait_cnt[i] <= wait_cnt[i] - 3'h1;
      end
    end
  end
  // credit only ever as an answer to a greeting
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      xl_ev[i] = {ovf_req[i], bad_req[i], iss_lvl[i], wait_cnt[i] == 3'h1};
    end
  end
endmodule
`default_nettype wire

/* File: verification/lcs_link_regs_bench.sv */
// lcs_link_regs_bench: self-checking bench of the link register bank
`timescale 1ns/10ps
`default_nettype none
module lcs_link_regs_bench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [2:0] LETTER [8] = '{3'h2, 3'h3, 3'h0, 3'h1, 3'h6, 3'h7, 3'h4, 3'h5};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]                     paddr = 12'h000;
  logic [31:0]                     pwdata = 32'h0, prdata, rd, wd, r;
  logic [31:0]                     cfg [8];       // last written ext config
  logic                            pready, pslverr, err;
  lcs_pkg::lcs_pl_stat_s [7:0]     pl_stat = '0;
  lcs_pkg::lcs_xl_ev_s [7:0]       xl_ev;
  logic [7:0][1:0]                 pl_network;
  lcs_pkg::lcs_xl_cfg_s [7:0]      xl_cfg;
  lcs_pkg::lcs_st_cfg_s [7:0]      st_cfg;
  logic [7:0] xl_greet, xl_rx_reset, xl_cred_held;
  logic [7:0] ovf_req = 8'h00, bad_req = 8'h00, iss_lvl = 8'h00;
  int error_cnt = 0, n_compared = 0, seed;
  int greet_cnt [8] = '{default: 0}, rrst_cnt [8] = '{default: 0};

  always #50 pclk = ~pclk;

  lcs_link_regs #(.NUM_PL(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pl_stat(pl_stat), .xl_ev(xl_ev),
    .pl_network(pl_network), .xl_cfg(xl_cfg), .xl_greet(xl_greet),
    .xl_rx_reset(xl_rx_reset), .xl_cred_held(xl_cred_held), .st_cfg(st_cfg));
  lcs_link_model partner (.pclk(pclk), .presetn(presetn), .xl_greet(xl_greet),
    .ovf_req(ovf_req), .bad_req(bad_req), .iss_lvl(iss_lvl), .xl_ev(xl_ev));

  // pulse counters: a stuck pulse shows as a surplus count
  always @(posedge pclk) begin
    for (int i = 0; i < 8; i++) begin
      greet_cnt[i] += (xl_greet[i] === 1'b1);
      rrst_cnt[i] += (xl_rx_reset[i] === 1'b1);
    end
  end
  // ----------------------------------------------------------------
  // tasks and expectations
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      error_cnt++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // bounded wait for the remote credit to land
  task automatic wait_held(input int n);
    int k;
    for (k = 0; k < 20; k++) begin
      if (xl_cred_held[n] === 1'b1) break;
      @(posedge pclk);
    end
    if (k == 20) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  function automatic logic [11:0] xa(input int n);
    return 12'h200 + 12'(4 * n);
  endfunction
  function automatic logic [31:0] xl_exp(input logic [31:0] d, input logic e, i, h);
    return {d[31:30], 2'h0, e, i, h, 3'h0, d[21:0]};
  endfunction
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h58c1e299;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, xa(0), 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h280, 32'h0);
    check(rd, 32'h0);
    // processor links: every target kind, random status and network
    for (int n = 0; n < 8; n++) begin
      r = $random(seed);
      r[12:11] = n[1:0];
      pl_stat[n] <= lcs_pkg::lcs_pl_stat_s'(r[12:0]);
      wd = $random(seed);
      apb(1'b1, 12'h100 + 12'(4 * n), wd);
      @(posedge pclk); // write lands at the access edge; look one edge later
      check({30'h0, pl_network[n]}, {30'h0, wd[5:4]});
      apb(1'b0, 12'h100 + 12'(4 * n), 32'h0);
      check(rd, {6'h0, r[12:3], 10'h0, wd[5:4], 1'h0, r[2:0]});
    end
    // external links: fields, array placement, greeting and credit
    for (int n = 0; n < 8; n++) begin
      iss_lvl[n] <= n[0];
      cfg[n] = (n == 7) ? 32'hFE7F_FFFF : ($random(seed) & 32'hFE7F_FFFF);
      apb(1'b1, xa(n), cfg[n]);
      @(posedge pclk); // settings settle after the access edge
      check(xl_cfg[n], {cfg[n][31:30], cfg[n][21:0]});
      apb(1'b0, xa(n), 32'h0);
      check(rd, xl_exp(cfg[n], 1'b0, n[0], 1'b0));
      apb(1'b1, xa(n), cfg[n] | 32'h0100_0000);
      wait_held(n);
      apb(1'b0, xa(n), 32'h0);
      check(rd, xl_exp(cfg[n], 1'b0, n[0], 1'b1));
      apb(1'b1, xa(n), cfg[n] | 32'h0100_0000);
      if (n[0]) begin
        apb(1'b0, xa(n), 32'h0);
        check(rd, xl_exp(cfg[n], 1'b0, 1'b1, 1'b0));
      end
      wait_held(n);
    end
    // overflow then bad token, each cleared by a receiver reset
    for (int f = 0; f < 2; f++) begin
      @(posedge pclk);
      ovf_req[3] <= (f == 0);
      bad_req[3] <= (f == 1);
      @(posedge pclk);
      ovf_req <= 8'h00;
      bad_req <= 8'h00;
      apb(1'b0, xa(3), 32'h0);
      check(rd, xl_exp(cfg[3], 1'b1, 1'b1, 1'b1));
      apb(1'b1, xa(3), cfg[3] | 32'h0080_0000);
      apb(1'b0, xa(3), 32'h0);
      check(rd, xl_exp(cfg[3], 1'b0, 1'b1, 1'b1));
    end
    for (int n = 0; n < 8; n++) begin
      check(greet_cnt[n], 2);
      check(rrst_cnt[n], (n == 3) ? 2 : 0);
    end
    // static forwarding in lettered order
    for (int s = 0; s < 8; s++) begin
      wd = $random(seed);
      apb(1'b1, 12'h280 + 12'(4 * s), wd);
      apb(1'b0, 12'h280 + 12'(4 * s), 32'h0);
      check(rd, wd & 32'h8000_011F);
      check(st_cfg[LETTER[s]], {wd[31], wd[8], wd[4:0]});
    end
    // unmapped read, unaligned write refused and ignored
    apb(1'b0, 12'h300, 32'h0);
    check(rd, 32'h0);
    check(err, 1'b1);
    apb(1'b1, 12'h202, 32'hFFFF_FFFF);
    check(err, 1'b1);
    apb(1'b0, xa(0), 32'h0);
    check(rd, xl_exp(cfg[0], 1'b0, 1'b0, 1'b1));
    tally_and_finish();
  end
endmodule
`default_nettype wire
